// ### shared/alert_event_pkg.sv
`default_nettype none
package alert_event_pkg;
  localparam int          ChannelCount   = 8;
  localparam int          AddrWidth      = 8;
  localparam int          DataWidth      = 8;
  localparam logic [7:0]  AddrScanEnable = 8'h12;
  localparam logic [7:0]  AddrNotifyMask = 8'h14;
  localparam logic [7:0]  AddrCrcMap     = 8'h16;
  localparam logic [7:0]  AddrPinSetup   = 8'h17;
  localparam logic [7:0]  AddrStatus     = 8'h18;
  localparam logic [7:0]  AddrUpperLatch = 8'h1A;
  localparam logic [7:0]  AddrLowerLatch = 8'h1C;
  localparam logic [7:0]  ResetByte      = 8'h00;
  localparam int          CrcEnableBit   = 0;
  localparam int          DriveBit       = 2;
  localparam int          PolarityLsb    = 0;
  localparam int          PolarityWidth  = 2;
  localparam logic [1:0]  PolLevelLow    = 2'h0;
  localparam logic [1:0]  PolLevelHigh   = 2'h1;
  localparam logic [1:0]  PolPulseLow    = 2'h2;
  localparam logic [1:0]  PolPulseHigh   = 2'h3;
  localparam int          PulseTimeNs    = 1000;
  localparam int          ClockPeriodNs  = 10;
  localparam int          PulseCycles    = PulseTimeNs / ClockPeriodNs;
  localparam int          PulseCntWidth  = 8;
endpackage
`default_nettype wire

// ### verilog/alert_event_flag_logic.sv
// What this block does
// - Scan enable bits choose which channels join the automatic scan.
// - A channel alerts the pin only when its notify mask bit is one.
// - CRC notify bit clear keeps the pin idle despite a CRC error.
// - CRC notify bit set makes a set CRC error flag an alert cause: steady in level modes, one pulse in pulse modes.
// - Setup bit 2 picks open-drain at zero, push-pull at one.
// - Polarity 00 gives steady active low, 01 steady active high.
// - Polarity 10 gives one low pulse, 11 one high pulse per alert.
// - Status register shows one read-only event bit per channel.
// - Status clears only through the upper and lower latches.
// - Upper latch sets on high threshold or digital one.
// - Writing one clears an upper latch bit; zero leaves it.
// - Reserved bits of CRC map and pin setup read as zero.
// - All registers of this block reset to zero, except pinRelease_q, which resets to one.
// - Lower latch sets on low threshold or digital zero; write one clears.
// - With scan go set in auto mode, enabled channels convert in ascending order.
`timescale 1ns/1ps
`default_nettype none
module alert_event_flag_logic #(
  parameter int Channels = alert_event_pkg::ChannelCount
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regWrite,
  input  wire logic [7:0]             regWdata,
  output logic      [7:0]             regRdata,
  input  wire logic [Channels-1:0]    upperEvent,
  input  wire logic [Channels-1:0]    lowerEvent,
  input  wire logic                   inputCrcErrorFlag,
  input  wire logic                   scanGo,
  input  wire logic [1:0]             scanSelectionMode,
  input  wire logic                   conversionDone,
  output logic [Channels-1:0]         scanChannelEnable,
  output logic [2:0]                  scanChannel,
  output logic                        scanActive,
  output logic                        alertOut,
  output logic                        alertOe_n
);
  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [Channels-1:0] scanEnable_q, scanEnable_d;
  logic [Channels-1:0] notifyMask_q, notifyMask_d;
  logic                crcNotify_q, crcNotify_d;
  logic                drivePushPull_q, drivePushPull_d;
  logic [1:0]          polarity_q, polarity_d;
  logic [Channels-1:0] upperLatch_q, upperLatch_d;
  logic [Channels-1:0] lowerLatch_q, lowerLatch_d;
  logic [Channels-1:0] status;

  always_comb begin
    scanEnable_d    = scanEnable_q;
    notifyMask_d    = notifyMask_q;
    crcNotify_d     = crcNotify_q;
    drivePushPull_d = drivePushPull_q;
    polarity_d      = polarity_q;
    upperLatch_d    = upperLatch_q;
    lowerLatch_d    = lowerLatch_q;
    if (regWrite) begin
      case (regAddr)
        alert_event_pkg::AddrScanEnable: scanEnable_d = regWdata[Channels-1:0];
        alert_event_pkg::AddrNotifyMask: notifyMask_d = regWdata[Channels-1:0];
        alert_event_pkg::AddrCrcMap:     crcNotify_d  = regWdata[alert_event_pkg::CrcEnableBit];
        alert_event_pkg::AddrPinSetup: begin
          drivePushPull_d = regWdata[alert_event_pkg::DriveBit];
          polarity_d      = regWdata[alert_event_pkg::PolarityLsb +: alert_event_pkg::PolarityWidth];
        end
        alert_event_pkg::AddrUpperLatch: upperLatch_d = upperLatch_q & ~regWdata[Channels-1:0];
        alert_event_pkg::AddrLowerLatch: lowerLatch_d = lowerLatch_q & ~regWdata[Channels-1:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle clear
    upperLatch_d = upperLatch_d | upperEvent;
    lowerLatch_d = lowerLatch_d | lowerEvent;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scanEnable_q    <= alert_event_pkg::ResetByte[Channels-1:0];
      notifyMask_q    <= alert_event_pkg::ResetByte[Channels-1:0];
      crcNotify_q     <= 1'b0;
      drivePushPull_q <= 1'b0;
      polarity_q      <= 2'h0;
      upperLatch_q    <= alert_event_pkg::ResetByte[Channels-1:0];
      lowerLatch_q    <= alert_event_pkg::ResetByte[Channels-1:0];
    end else begin
      scanEnable_q    <= scanEnable_d;
      notifyMask_q    <= notifyMask_d;
      crcNotify_q     <= crcNotify_d;
      drivePushPull_q <= drivePushPull_d;
      polarity_q      <= polarity_d;
      upperLatch_q    <= upperLatch_d;
      lowerLatch_q    <= lowerLatch_d;
    end
  end

  // ***********************************************************
  // Status and scan mask
  // ***********************************************************
  assign status            = upperLatch_q | lowerLatch_q;
  assign scanChannelEnable = scanEnable_q;

  // ***********************************************************
  // Read mux
  // ***********************************************************
  always_comb begin
    regRdata = 8'h00;
    case (regAddr)
      alert_event_pkg::AddrScanEnable: regRdata[Channels-1:0] = scanEnable_q;
      alert_event_pkg::AddrNotifyMask: regRdata[Channels-1:0] = notifyMask_q;
      alert_event_pkg::AddrCrcMap:     regRdata[alert_event_pkg::CrcEnableBit] = crcNotify_q;
      alert_event_pkg::AddrPinSetup: begin
        regRdata[alert_event_pkg::DriveBit] = drivePushPull_q;
        regRdata[alert_event_pkg::PolarityLsb +: alert_event_pkg::PolarityWidth] = polarity_q;
      end
      alert_event_pkg::AddrStatus:     regRdata[Channels-1:0] = status;
      alert_event_pkg::AddrUpperLatch: regRdata[Channels-1:0] = upperLatch_q;
      alert_event_pkg::AddrLowerLatch: regRdata[Channels-1:0] = lowerLatch_q;
      default: regRdata = 8'h00;
    endcase
  end

  // ***********************************************************
  // Alert cause
  // ***********************************************************
  logic                                      notifyHit;
  logic                                      crcHit;
  logic                                      alertCause;
  logic                                      alertCause_q;
  logic                                      pulsedMode;
  logic [alert_event_pkg::PulseCntWidth-1:0] pulseCnt_q, pulseCnt_d;
  logic                                      alertActive;
  logic                                      pinLevel;
  logic                                      pinOut_q, pinOut_d;
  logic                                      pinRelease_q, pinRelease_d;

  assign notifyHit  = |(status & notifyMask_q);
  assign crcHit     = crcNotify_q & inputCrcErrorFlag;
  assign alertCause = notifyHit | crcHit;
  assign pulsedMode = (polarity_q == alert_event_pkg::PolPulseLow)
                    | (polarity_q == alert_event_pkg::PolPulseHigh);

  // ***********************************************************
  // Pulse timer
  // ***********************************************************
  always_comb begin
    pulseCnt_d = pulseCnt_q;
    if (!pulsedMode) begin
      // Idle in level modes, so no stale pulse shows after a mode change
      pulseCnt_d = '0;
    end else if (alertCause && !alertCause_q) begin
      pulseCnt_d = alert_event_pkg::PulseCntWidth'(alert_event_pkg::PulseCycles);
    end else if (pulseCnt_q != '0) begin
      pulseCnt_d = pulseCnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alertCause_q <= 1'b0;
      pulseCnt_q   <= '0;
    end else begin
      alertCause_q <= alertCause;
      pulseCnt_q   <= pulseCnt_d;
    end
  end

  // ***********************************************************
  // Pin level
  // ***********************************************************
  always_comb begin
    alertActive = 1'b0;
    pinLevel    = 1'b1;
    case (polarity_q)
      alert_event_pkg::PolLevelLow: begin
        alertActive = alertCause;
        pinLevel    = ~alertActive;
      end
      alert_event_pkg::PolLevelHigh: begin
        alertActive = alertCause;
        pinLevel    = alertActive;
      end
      alert_event_pkg::PolPulseLow: begin
        alertActive = pulseCnt_q != '0;
        pinLevel    = ~alertActive;
      end
      alert_event_pkg::PolPulseHigh: begin
        alertActive = pulseCnt_q != '0;
        pinLevel    = alertActive;
      end
      default: begin
        alertActive = 1'b0;
        pinLevel    = 1'b1;
      end
    endcase
  end

  // ***********************************************************
  // Pin drive
  // ***********************************************************
  always_comb begin
    pinOut_d     = 1'b0;
    pinRelease_d = 1'b0;
    if (drivePushPull_q) begin
      pinOut_d = pinLevel;
    end else begin
      // Open drain only pulls low and releases for high
      pinRelease_d = pinLevel;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_q     <= 1'b0;
      pinRelease_q <= 1'b1;
    end else begin
      pinOut_q     <= pinOut_d;
      pinRelease_q <= pinRelease_d;
    end
  end

  // Registered pin keeps mode changes free of glitches
  assign alertOut  = pinOut_q;
  assign alertOe_n = pinRelease_q;

  // ***********************************************************
  // Auto scan sequencer
  // ***********************************************************
  typedef enum logic [0:0] {ScanIdle, ScanRun} scan_state_e;
  scan_state_e state_q, state_d;
  logic [2:0]  chan_q, chan_d;
  logic [2:0]  nextChan;
  logic [2:0]  firstChan;
  logic        found;
  logic        foundFirst;
  logic        autoGo;
  logic        anyEnabled;

  assign autoGo     = scanGo && (scanSelectionMode == 2'h1);
  assign anyEnabled = |scanEnable_q;

  // Lowest enabled channel opens each sequence
  always_comb begin
    firstChan  = 3'h0;
    foundFirst = 1'b0;
    for (int i = 0; i < Channels; i++) begin
      if (!foundFirst && scanEnable_q[i]) begin
        foundFirst = 1'b1;
        firstChan  = 3'(i);
      end
    end
  end

  // Next enabled channel above the current one, wrapping round
  always_comb begin
    nextChan = chan_q;
    found    = 1'b0;
    for (int i = 1; i <= Channels; i++) begin
      if (!found && scanEnable_q[(int'(chan_q) + i) % Channels]) begin
        found    = 1'b1;
        nextChan = 3'((int'(chan_q) + i) % Channels);
      end
    end
  end

  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    case (state_q)
      ScanIdle: begin
        if (autoGo && anyEnabled) begin
          state_d = ScanRun;
          chan_d  = firstChan;
        end
      end
      ScanRun: begin
        if (!autoGo || !anyEnabled) begin
          state_d = ScanIdle;
        end else if (conversionDone || !scanEnable_q[chan_q]) begin
          chan_d = nextChan;
        end
      end
      default: begin
        state_d = ScanIdle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ScanIdle;
      chan_q  <= 3'h0;
    end else begin
      state_q <= state_d;
      chan_q  <= chan_d;
    end
  end

  assign scanActive  = state_q == ScanRun;
  assign scanChannel = chan_q;
endmodule
`default_nettype wire

// ### verification/alert_event_flag_logic_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Alert block checks
// ****************
module alert_event_flag_logic_monitor #(
  parameter int Channels = alert_event_pkg::ChannelCount
) (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                regWrite,
  input wire logic                alertOut,
  input wire logic                alertOe_n,
  input wire logic [7:0]          regAddr,
  input wire logic [7:0]          regWdata,
  input wire logic [7:0]          regRdata,
  input wire logic [Channels-1:0] upperEvent,
  input wire logic [Channels-1:0] scanChannelEnable
);
  logic [2:0] pinCfg_q;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) pinCfg_q <= 3'h0;
    else if (regWrite && regAddr == alert_event_pkg::AddrPinSetup) pinCfg_q <= regWdata[2:0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_hold; alertOut [*8]; endsequence
  property p_crc_rsv; regAddr == alert_event_pkg::AddrCrcMap |-> regRdata[7:1] == 7'h00; endproperty
  a_crc_rsv: assert property (p_crc_rsv) else $error("crc map reserved bit set");
  property p_cfg_rsv; regAddr == alert_event_pkg::AddrPinSetup |-> regRdata[7:3] == 5'h00; endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("pin setup reserved bit set");
  property p_scan; regWrite && regAddr == alert_event_pkg::AddrScanEnable |=> scanChannelEnable == $past(regWdata); endproperty
  a_scan: assert property (p_scan) else $error("scan enable not taken");
  property p_up_set; (upperEvent != '0) ##1 (regAddr == alert_event_pkg::AddrUpperLatch)
    |-> (regRdata & $past(upperEvent)) == $past(upperEvent); endproperty
  a_up_set: assert property (p_up_set) else $error("upper latch not set");
  property p_w1c; (regWrite && regAddr == alert_event_pkg::AddrUpperLatch && regWdata == 8'hFF && upperEvent == '0)
    ##1 (regAddr == alert_event_pkg::AddrUpperLatch) |-> regRdata == 8'h00; endproperty
  a_w1c: assert property (p_w1c) else $error("upper latch not cleared");
  property p_open; !pinCfg_q[2] && !$past(pinCfg_q[2]) |-> alertOe_n || !alertOut; endproperty
  a_open: assert property (p_open) else $error("open drain drives high");
  property p_push; pinCfg_q[2] && $past(pinCfg_q[2]) |-> !alertOe_n; endproperty
  a_push: assert property (p_push) else $error("push pull released");
  property p_pulse; pinCfg_q == 3'h7 && $rose(alertOut) |=> s_hold; endproperty
  a_pulse: assert property (p_pulse) else $error("high pulse too short");
endmodule
bind alert_event_flag_logic alert_event_flag_logic_monitor #(.Channels(Channels)) u_mon (.clock(clock),
  .rst_n(rst_n), .regWrite(regWrite), .alertOut(alertOut), .alertOe_n(alertOe_n), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata), .upperEvent(upperEvent), .scanChannelEnable(scanChannelEnable));
`default_nettype wire

// ### verification/alert_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host side of the register port and pin
// ****************
module alert_host_model (
  input  wire logic       clock,
  input  wire logic       alertOut,
  input  wire logic       alertOe_n,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            alertPin,
  output logic            readValid,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic      [7:0] readData
);
  assign alertPin = alertOe_n ? 1'b1 : alertOut; // Pull-up when released
  initial {regWrite, readValid, regAddr, regWdata, readData} = '0;
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1; // W1C clears come only from here
    @(posedge clock);
    #1 regWrite = 1'b0;
    regWdata = ~d;
    // One idle edge keeps back-to-back writes apart
    @(posedge clock);
    #1;
  endtask
  task automatic readReg(input logic [7:0] a);
    regAddr = a;
    @(posedge clock);
    readData = regRdata;
    readValid = 1'b1;
    #1 readValid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/test_alert_event_flag_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_alert_event_flag_logic;
  logic clock, rst_n, regWrite, inputCrcErrorFlag, scanGo, conversionDone, scanActive, alertOut, alertOe_n;
  logic alertPin, readValid;
  logic [7:0] regAddr, regWdata, regRdata, upperEvent, lowerEvent, scanChannelEnable, readData, r, m;
  logic [7:0] expQ[$];
  logic [7:0] addrs[7] = '{8'h12, 8'h14, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1C};
  logic [2:0] scanChannel;
  logic [1:0] scanSelectionMode;
  int num_errors = 0, comparisons = 0, n;
  alert_event_flag_logic u_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .upperEvent(upperEvent), .lowerEvent(lowerEvent),
    .inputCrcErrorFlag(inputCrcErrorFlag), .scanGo(scanGo), .scanSelectionMode(scanSelectionMode),
    .conversionDone(conversionDone), .scanChannelEnable(scanChannelEnable), .scanChannel(scanChannel),
    .scanActive(scanActive), .alertOut(alertOut), .alertOe_n(alertOe_n));
  alert_host_model u_host (.clock(clock), .alertOut(alertOut), .alertOe_n(alertOe_n), .regRdata(regRdata),
    .regWrite(regWrite), .alertPin(alertPin), .readValid(readValid), .regAddr(regAddr), .regWdata(regWdata),
    .readData(readData));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic checkVal(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    u_host.readReg(a);
  endtask
  task automatic waitPin(input logic v);
    n = 0;
    while (alertPin !== v && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    checkVal("alert pin", {7'h00, v}, {7'h00, alertPin});
    if (alertPin !== v) stop_test();
  endtask
  // Scoreboard: each read result against the oldest note
  always @(posedge readValid) begin
    if (expQ.size() == 0) begin
      num_errors++;
      $display("unexpected register read expected none seen %h", readData);
    end else begin
      checkVal("register read", expQ.pop_front(), readData);
    end
  end
  initial begin
    {rst_n, upperEvent, lowerEvent, inputCrcErrorFlag, scanGo, scanSelectionMode, conversionDone} = '0;
    r = $urandom(28548);
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    checkVal("released oe", 8'h01, {7'h00, alertOe_n});
    r = $urandom;
    m = $urandom;
    u_host.writeReg(8'h12, r);
    u_host.writeReg(8'h14, m);
    rd(8'h12, r);
    rd(8'h14, m);
    checkVal("scan enable", r, scanChannelEnable);
    u_host.writeReg(8'h16, 8'hFF);
    u_host.writeReg(8'h17, 8'hF8);
    rd(8'h16, 8'h01);
    rd(8'h17, 8'h00);
    rd(8'h13, 8'h00);
    r = $urandom;
    m = $urandom;
    upperEvent = r;
    lowerEvent = m;
    @(posedge clock);
    #1 {upperEvent, lowerEvent} = '0;
    rd(8'h1A, r);
    rd(8'h1C, m);
    rd(8'h18, r | m);
    u_host.writeReg(8'h18, 8'hFF);
    rd(8'h18, r | m);
    u_host.writeReg(8'h1A, 8'h0F);
    u_host.writeReg(8'h1C, 8'hF0);
    rd(8'h18, (r & 8'hF0) | (m & 8'h0F));
    u_host.writeReg(8'h1A, 8'hFF);
    rd(8'h1A, 8'h00);
    u_host.writeReg(8'h1C, 8'hFF);
    rd(8'h18, 8'h00);
    u_host.writeReg(8'h16, 8'h00);
    u_host.writeReg(8'h14, 8'h01);
    upperEvent = 8'h02;
    inputCrcErrorFlag = 1'b1;
    @(posedge clock);
    #1 upperEvent = 8'h00;
    repeat (4) @(posedge clock);
    #1 checkVal("masked pin", 8'h01, {7'h00, alertPin});
    lowerEvent = 8'h01;
    @(posedge clock);
    #1 lowerEvent = 8'h00;
    waitPin(1'b0);
    checkVal("open drain low", 8'h00, {7'h00, alertOut});
    u_host.writeReg(8'h1C, 8'h01);
    waitPin(1'b1);
    u_host.writeReg(8'h1A, 8'h02);
    u_host.writeReg(8'h17, 8'h05);
    u_host.writeReg(8'h16, 8'h01);
    waitPin(1'b1);
    checkVal("push pull oe", 8'h00, {7'h00, alertOe_n});
    inputCrcErrorFlag = 1'b0;
    waitPin(1'b0);
    u_host.writeReg(8'h17, 8'h07);
    upperEvent = 8'h01;
    @(posedge clock);
    #1 upperEvent = 8'h00;
    waitPin(1'b1);
    n = 0;
    while (alertPin === 1'b1 && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
    checkVal("pulse length", 8'(alert_event_pkg::PulseCycles), n[7:0]);
    repeat (20) @(posedge clock);
    #1 checkVal("single pulse", 8'h00, {7'h00, alertPin});
    u_host.writeReg(8'h1A, 8'h01);
    u_host.writeReg(8'h17, 8'h06);
    waitPin(1'b1);
    upperEvent = 8'h01;
    @(posedge clock);
    #1 upperEvent = 8'h00;
    waitPin(1'b0);
    waitPin(1'b1);
    u_host.writeReg(8'h12, 8'h24);
    scanSelectionMode = 2'h1;
    scanGo = 1'b1;
    repeat (4) @(posedge clock);
    #1 checkVal("first channel", 8'h02, {5'h00, scanChannel});
    checkVal("scan active", 8'h01, {7'h00, scanActive});
    conversionDone = 1'b1;
    @(posedge clock);
    #1 conversionDone = 1'b0;
    repeat (3) @(posedge clock);
    #1 checkVal("next channel", 8'h05, {5'h00, scanChannel});
    scanGo = 1'b0;
    u_host.writeReg(8'h12, 8'h81);
    scanGo = 1'b1;
    repeat (2) @(posedge clock);
    #1 checkVal("lowest first channel", 8'h00, {5'h00, scanChannel});
    conversionDone = 1'b1;
    @(posedge clock);
    #1 conversionDone = 1'b0;
    checkVal("ascending next", 8'h07, {5'h00, scanChannel});
    scanSelectionMode = 2'h0;
    repeat (2) @(posedge clock);
    #1 checkVal("manual mode stops", 8'h00, {7'h00, scanActive});
    stop_test();
  end
endmodule
`default_nettype wire
